/* File: design/brol_pkg.sv */
// package: constants, register map and types of the bridge reset and option latch
package brol_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int CLK_KHZ = 125000;
    localparam int VME_STRETCH_MS = 256;
    localparam int PCI_STRETCH_MS = 5;
    localparam int VME_STRETCH_CYCLES = VME_STRETCH_MS * CLK_KHZ;
    localparam int PCI_STRETCH_CYCLES = PCI_STRETCH_MS * CLK_KHZ;
    localparam int LATCH_WINDOW_PS = 31250;
    localparam int LATCH_DLY_RAW = LATCH_WINDOW_PS / CLK_PERIOD_PS;
    localparam int LATCH_DLY_CYCLES = (LATCH_DLY_RAW < 1) ? 1 : LATCH_DLY_RAW;
    localparam int VCNT_W = 26;
    localparam int PCNT_W = 21;
    localparam int LCNT_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // synchronised input vector layout
    localparam int ASYNC_W = 42;
    localparam int IN_POR = 0;
    localparam int IN_VSYS = 1;
    localparam int IN_PCIRST = 2;
    localparam int IN_REQ = 3;
    localparam int IN_REQ64 = 4;
    localparam int IN_BG3 = 5;
    localparam int IN_VD_LSB = 6;
    localparam int IN_VA_LSB = 11;
    localparam logic [ASYNC_W-1:0] ASYNC_RST = 42'h000_0000_003E;

    ////////////////////////////////////////////////////////////////////////////
    // option pin positions on the address lines (data lines as vd[31:27] -> bit 4..0)
    localparam int PIN_RAI_EN = 31;
    localparam int PIN_RAI_SP = 29;
    localparam int PIN_RAI_BS = 21;
    localparam int PIN_CR_SP = 20;
    localparam int PIN_CR_TO = 15;
    localparam int PIN_BM = 14;
    localparam int PIN_TI_EN = 13;
    localparam int PIN_TI_SP = 12;
    localparam int PIN_TI_VAS = 10;
    localparam int PIN_TI_BS = 6;
    localparam int PIN_TI_BD = 2;
    localparam int PIN_REG_SP = 1;
    localparam int PIN_DAISY = 3;
    localparam int PIN_V64 = 2;
    localparam int PIN_BI = 1;
    localparam int PIN_SYSFAIL = 0;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses) and bit positions
    localparam logic [7:0] OFS_GENCTL = 8'h00;
    localparam logic [7:0] OFS_CSR_SET = 8'h04;
    localparam logic [7:0] OFS_CSR_CLR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RAI = 8'h10;
    localparam logic [7:0] OFS_CRCSR = 8'h14;
    localparam logic [7:0] OFS_TI0 = 8'h18;
    localparam logic [7:0] OFS_PCICFG = 8'h1C;
    localparam int GC_SOFT_PCI = 0;
    localparam int GC_SOFT_VME = 1;
    localparam int GC_BI = 2;
    localparam int GC_V64 = 3;
    localparam int GC_SYSCON = 4;
    localparam int CSR_RESET = 0;
    localparam int CSR_SYSFAIL = 1;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic rai_en;
        logic [1:0] rai_space;
        logic [7:0] rai_base;
        logic crcsr_io;
        logic [4:0] crcsr_offset;
        logic daisy_chain_autoid;
        logic vme64_autoid_enable;
        logic bus_isolation_mode;
        logic sysfail_assert;
        logic ti0_en;
        logic ti0_io;
        logic [1:0] ti0_vme_space_select;
        logic [3:0] ti0_base;
        logic [3:0] ti0_bound;
        logic bus_master_enable;
        logic pci_reg_base0_io;
    } brol_opt_type;

    localparam brol_opt_type OPT_DEFAULT = '0;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_WAIT,
        ST_LATCH,
        ST_ENABLE,
        ST_VHOLD,
        ST_RUN
    } brol_fsm_type;

    typedef struct packed {
        logic por;
        logic vme;
        logic general;
        logic clk_services_ok;
    } brol_domain_type;

endpackage : brol_pkg

/* File: design/brol_top.sv */
// module: reset sequencing, reset stretching and power-up option latch with an APB register slave
//
// Behaviour
// - clock services cleared only by power-on reset
// - VME services and power-up machine reset on power-on or Request_in_a; rest also PCI
// - power-on reset resets every domain including both reset outputs
// - Request_in_a output held 256 ms after last initiator goes away
// - Request_in_a output initiated by power-on, reset request pin or soft bit
// - PCI reset output held at least 5 ms from power-on, soft bit, set bit
// - set register bits assert PCI reset or system-fail until matching clear write
// - writing 1 to clear register reset bit negates the PCI reset output
// - options sampled from VME address and data lines after power-on reset
// - PCI width loaded from its request pin on every PCI reset
// - system controller enable loaded during Request_in_a from bus-grant 3 input
// - all option pins captured on release of power-on reset
// - later VME or PCI resets reload captured options except width and syscon
// - options applied only while all three reset inputs are negated
// - register image enable, space and base from address lines 31..21
// - CR/CSR image space from line 20, offset from lines 19..15
// - data lines 30..27 set auto-IDs, isolation and system-fail assertion
// - target image 0 and bus master and register space from address lines
// - enabled target image 0 sets memory or I/O enable in PCI command
// - Request_in_a input asserts PCI reset output, resets device, reloads options
// - options latched three fast clock periods after power-on release, transceivers enabled one later
// - soft reset bits act on write of 1 only and read back 0
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
module brol_top
    import brol_pkg::*;
#(
    parameter logic [VCNT_W-1:0] VME_STRETCH_CYC = VCNT_W'(VME_STRETCH_CYCLES),
    parameter logic [PCNT_W-1:0] PCI_STRETCH_CYC = PCNT_W'(PCI_STRETCH_CYCLES)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_on_reset_in_n,
    input wire logic vme_sysreset_in_n,
    input wire logic pci_reset_in_n,
    input wire logic request_in_a_n,
    input wire logic req64_n,
    input wire logic bus_grant3_in_n,
    input wire logic [31:1] vme_addr_lines,
    input wire logic [31:27] vme_data_lines,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic vme_sysreset_out,
    output logic local_pci_reset_out_n,
    output logic sysfail_out,
    output logic vme_xcvr_out_enable,
    output brol_domain_type domain_reset,
    output brol_opt_type options,
    output logic pci_width_status
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [ASYNC_W-1:0] s1;
        logic [ASYNC_W-1:0] s2;
        logic [ASYNC_W-1:0] s3;
        logic [ASYNC_W-1:0] flt;
        logic por_d;
        brol_fsm_type fsm;
        logic [LCNT_W-1:0] lcnt;
        brol_opt_type captured;
        brol_opt_type applied;
        logic pending;
        logic applied_ok;
        logic [VCNT_W-1:0] vcnt;
        logic [PCNT_W-1:0] pcnt;
        logic vme_out;
        logic pci_out_n;
        logic csr_reset;
        logic sysfail;
        logic xcvr_en;
        logic width64;
        logic syscon;
        brol_domain_type dom;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } brol_state_type;

    brol_state_type state_r;
    brol_state_type state_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction : reg_hit

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = reg_hit(addr, OFS_GENCTL) | reg_hit(addr, OFS_CSR_SET) | reg_hit(addr, OFS_CSR_CLR)
            | reg_hit(addr, OFS_STATUS) | reg_hit(addr, OFS_RAI) | reg_hit(addr, OFS_CRCSR)
            | reg_hit(addr, OFS_TI0) | reg_hit(addr, OFS_PCICFG);
    endfunction : addr_mapped

    function automatic brol_opt_type opt_from_pins(input logic [31:0] va, input logic [4:0] vd);
        brol_opt_type o;
        o = OPT_DEFAULT;
        o.rai_en = va[PIN_RAI_EN];
        o.rai_space = va[PIN_RAI_SP +: 2];
        o.rai_base = va[PIN_RAI_BS +: 8];
        o.crcsr_io = va[PIN_CR_SP];
        o.crcsr_offset = va[PIN_CR_TO +: 5];
        o.bus_master_enable = va[PIN_BM];
        o.ti0_en = va[PIN_TI_EN];
        o.ti0_io = va[PIN_TI_SP];
        o.ti0_vme_space_select = va[PIN_TI_VAS +: 2];
        o.ti0_base = va[PIN_TI_BS +: 4];
        o.ti0_bound = va[PIN_TI_BD +: 4];
        // low pin selects I/O space for base 0
        o.pci_reg_base0_io = ~va[PIN_REG_SP];
        o.daisy_chain_autoid = vd[PIN_DAISY];
        o.vme64_autoid_enable = vd[PIN_V64];
        o.bus_isolation_mode = vd[PIN_BI];
        // pulled-down pin means assert system-fail
        o.sysfail_assert = ~vd[PIN_SYSFAIL];
        opt_from_pins = o;
    endfunction : opt_from_pins

    function automatic logic [31:0] rd_word(input logic [7:0] addr, input brol_state_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (reg_hit(addr, OFS_GENCTL)) begin
            // soft reset bits always read back 0
            w[GC_BI] = s.applied.bus_isolation_mode;
            w[GC_V64] = s.applied.vme64_autoid_enable;
            w[GC_SYSCON] = s.syscon;
        end
        if (reg_hit(addr, OFS_CSR_SET) || reg_hit(addr, OFS_CSR_CLR)) begin
            w[CSR_RESET] = ~s.pci_out_n;
            w[CSR_SYSFAIL] = s.sysfail;
        end
        if (reg_hit(addr, OFS_STATUS)) begin
            w[5:0] = {s.applied_ok, s.dom.clk_services_ok, ~s.pci_out_n, s.vme_out,
                      s.applied.daisy_chain_autoid, s.width64};
        end
        if (reg_hit(addr, OFS_RAI)) begin
            w[2:0] = {s.applied.rai_space, s.applied.rai_en};
            w[15:8] = s.applied.rai_base;
        end
        if (reg_hit(addr, OFS_CRCSR)) begin
            w[0] = s.applied.crcsr_io;
            w[12:8] = s.applied.crcsr_offset;
        end
        if (reg_hit(addr, OFS_TI0)) begin
            w[11:0] = {s.applied.ti0_bound, s.applied.ti0_base, s.applied.ti0_vme_space_select,
                       s.applied.ti0_io, s.applied.ti0_en};
        end
        if (reg_hit(addr, OFS_PCICFG)) begin
            w[0] = s.applied.ti0_en & ~s.applied.ti0_io;
            w[1] = s.applied.ti0_en & s.applied.ti0_io;
            w[2] = s.applied.bus_master_enable;
            w[3] = s.applied.pci_reg_base0_io;
        end
        rd_word = w;
    endfunction : rd_word

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic por;
        logic vsys;
        logic pcir;
        logic vreq;
        logic acc_wr;
        logic soft_pci;
        logic soft_vme;
        logic set_reset;
        logic set_fail;
        logic clr_reset;
        logic clr_fail;
        logic vinit;
        logic pinit;
        logic apply;
        logic [31:0] va;
        por = 1'b0;
        vsys = 1'b0;
        pcir = 1'b0;
        vreq = 1'b0;
        acc_wr = 1'b0;
        soft_pci = 1'b0;
        soft_vme = 1'b0;
        set_reset = 1'b0;
        set_fail = 1'b0;
        clr_reset = 1'b0;
        clr_fail = 1'b0;
        vinit = 1'b0;
        pinit = 1'b0;
        apply = 1'b0;
        va = 32'h0000_0000;
        state_nxt = state_r;

        // three-stage synchroniser; a change counts once stages two and three agree
        state_nxt.s1 = {vme_addr_lines, vme_data_lines, bus_grant3_in_n, req64_n, request_in_a_n,
                        pci_reset_in_n, vme_sysreset_in_n, power_on_reset_in_n};
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        state_nxt.flt = (~(state_r.s2 ^ state_r.s3) & state_r.s3)
                      | ((state_r.s2 ^ state_r.s3) & state_r.flt);

        por = ~state_r.flt[IN_POR];
        vsys = ~state_r.flt[IN_VSYS];
        pcir = ~state_r.flt[IN_PCIRST];
        vreq = ~state_r.flt[IN_REQ];
        va = {state_r.flt[IN_VA_LSB +: 31], 1'b0};
        state_nxt.por_d = por;

        // APB slave: one wait state, effects at the completing edge
        state_nxt.pready = 1'b0;
        if (psel && penable && !state_r.pready) begin
            state_nxt.pready = 1'b1;
            state_nxt.pslverr = ~addr_mapped(paddr);
            state_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word(paddr, state_r);
        end
        acc_wr = psel & penable & state_r.pready & pwrite;
        soft_pci = acc_wr & reg_hit(paddr, OFS_GENCTL) & pwdata[GC_SOFT_PCI];
        soft_vme = acc_wr & reg_hit(paddr, OFS_GENCTL) & pwdata[GC_SOFT_VME];
        set_reset = acc_wr & reg_hit(paddr, OFS_CSR_SET) & pwdata[CSR_RESET];
        set_fail = acc_wr & reg_hit(paddr, OFS_CSR_SET) & pwdata[CSR_SYSFAIL];
        clr_reset = acc_wr & reg_hit(paddr, OFS_CSR_CLR) & pwdata[CSR_RESET];
        clr_fail = acc_wr & reg_hit(paddr, OFS_CSR_CLR) & pwdata[CSR_SYSFAIL];

        // reset domains
        state_nxt.dom.por = por;
        state_nxt.dom.clk_services_ok = ~por;
        state_nxt.dom.vme = por | vsys;
        state_nxt.dom.general = por | vsys | pcir;

        // Request_in_a output and its stretch
        vinit = por | vreq | soft_vme;
        if (vinit) begin
            state_nxt.vcnt = VME_STRETCH_CYC;
        end else if (state_r.vcnt != '0) begin
            state_nxt.vcnt = state_r.vcnt - VCNT_W'(1);
        end
        state_nxt.vme_out = vinit | (state_r.vcnt != '0);

        // CSR set and clear bits; set beats clear
        if (clr_reset) begin
            state_nxt.csr_reset = 1'b0;
        end
        if (set_reset) begin
            state_nxt.csr_reset = 1'b1;
        end
        if (clr_fail) begin
            state_nxt.sysfail = 1'b0;
        end
        if (set_fail) begin
            state_nxt.sysfail = 1'b1;
        end
        if (por | vsys) begin
            state_nxt.csr_reset = 1'b0;
            state_nxt.sysfail = 1'b0;
        end

        // PCI reset output: stretched sources plus held CSR bit and Request_in_a input
        pinit = por | soft_pci | set_reset;
        if (pinit) begin
            state_nxt.pcnt = PCI_STRETCH_CYC;
        end else if (state_r.pcnt != '0) begin
            state_nxt.pcnt = state_r.pcnt - PCNT_W'(1);
        end
        state_nxt.pci_out_n = ~(pinit | (state_r.pcnt != '0) | state_nxt.csr_reset | vsys);

        // width and syscon follow their own pins during their reset
        if (pcir) begin
            state_nxt.width64 = ~state_r.flt[IN_REQ64];
        end
        if (vsys || por) begin
            state_nxt.syscon = ~state_r.flt[IN_BG3];
        end

        // power-up machine: latch window after power-on release, then transceivers
        case (state_r.fsm)
            ST_HOLD: begin
                state_nxt.xcvr_en = 1'b0;
                state_nxt.lcnt = LCNT_W'(LATCH_DLY_CYCLES);
                if (!por) begin
                    state_nxt.fsm = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (state_r.lcnt <= LCNT_W'(2)) begin
                    state_nxt.fsm = ST_LATCH;
                end else begin
                    state_nxt.lcnt = state_r.lcnt - LCNT_W'(1);
                end
            end
            ST_LATCH: begin
                state_nxt.captured = opt_from_pins(va, state_r.flt[IN_VD_LSB +: 5]);
                state_nxt.fsm = ST_ENABLE;
            end
            ST_ENABLE: begin
                state_nxt.xcvr_en = 1'b1;
                state_nxt.fsm = ST_RUN;
            end
            ST_VHOLD: begin
                state_nxt.xcvr_en = 1'b0;
                if (!vsys) begin
                    state_nxt.fsm = ST_ENABLE;
                end
            end
            ST_RUN: begin
                state_nxt.xcvr_en = 1'b1;
            end
            default: begin
                state_nxt.fsm = ST_HOLD;
            end
        endcase
        if (por) begin
            state_nxt.fsm = ST_HOLD;
            state_nxt.xcvr_en = 1'b0;
        end else if (vsys) begin
            state_nxt.fsm = ST_VHOLD;
            state_nxt.xcvr_en = 1'b0;
        end

        // apply captured options once every reset input is negated
        if (por | vsys | pcir) begin
            state_nxt.pending = 1'b1;
            state_nxt.applied = OPT_DEFAULT;
            state_nxt.applied_ok = 1'b0;
        end
        apply = state_r.pending & ~por & ~vsys & ~pcir & (state_r.fsm == ST_RUN);
        if (apply) begin
            state_nxt.applied = state_r.captured;
            state_nxt.applied_ok = 1'b1;
            state_nxt.pending = 1'b0;
            if (state_r.captured.sysfail_assert) begin
                state_nxt.sysfail = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= '0;
            state_r.s1 <= ASYNC_RST;
            state_r.s2 <= ASYNC_RST;
            state_r.s3 <= ASYNC_RST;
            state_r.flt <= ASYNC_RST;
            state_r.por_d <= 1'b1;
            state_r.fsm <= ST_HOLD;
            state_r.captured <= OPT_DEFAULT;
            state_r.applied <= OPT_DEFAULT;
            state_r.pending <= 1'b1;
            state_r.vme_out <= 1'b1;
            state_r.pci_out_n <= 1'b0;
            state_r.syscon <= 1'b1;
            state_r.dom <= '{por: 1'b1, vme: 1'b1, general: 1'b1, clk_services_ok: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign pready = state_r.pready;
    assign prdata = state_r.prdata;
    assign pslverr = state_r.pslverr;
    assign vme_sysreset_out = state_r.vme_out;
    assign local_pci_reset_out_n = state_r.pci_out_n;
    assign sysfail_out = state_r.sysfail;
    assign vme_xcvr_out_enable = state_r.xcvr_en;
    assign domain_reset = state_r.dom;
    assign options = state_r.applied;
    assign pci_width_status = state_r.width64;

endmodule : brol_top

/* File: sim/brol_far_side.sv */
// far-side model: board reset drivers and VME option straps
`timescale 1ns/10ps
module brol_far_side (
    input wire logic mclk,
    input wire logic [3:0] hold_n,
    input wire logic [37:0] straps,
    input wire logic xcvr_on,
    output logic [5:0] ctl_n,
    output logic [35:0] lines
);
    initial ctl_n = 6'h0A;
    initial lines = '0;
    always @(posedge mclk) begin
        // reset lengths set by the bench, outputs never looped back
        ctl_n <= {straps[37:36], hold_n};
        // lines carry traffic while transceivers drive: flips each cycle
        lines <= xcvr_on ? ~lines : straps[35:0];
    end
endmodule : brol_far_side

/* File: sim/brol_top_props.sv */
// checker: reset outputs, stretch times, option apply and APB wait state
`timescale 1ns/10ps
module brol_top_props
    import brol_pkg::*;
#(
    parameter logic [VCNT_W-1:0] VME_STRETCH_CYC = VCNT_W'(VME_STRETCH_CYCLES),
    parameter logic [PCNT_W-1:0] PCI_STRETCH_CYC = PCNT_W'(PCI_STRETCH_CYCLES)
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_on_reset_in_n,
    input wire logic vme_sysreset_in_n,
    input wire logic pci_reset_in_n,
    input wire logic request_in_a_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic vme_sysreset_out,
    input wire logic local_pci_reset_out_n,
    input wire logic vme_xcvr_out_enable,
    input wire brol_domain_type domain_reset,
    input wire brol_opt_type options
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // run lengths of both reset outputs and of the released pin
    int vhi_r = 0;
    int plo_r = 0;
    int phi_r = 0;
    bit vsaw_r = 0;
    always_ff @(posedge mclk) begin
        vhi_r <= vme_sysreset_out ? vhi_r + 1 : 0;
        plo_r <= local_pci_reset_out_n ? 0 : plo_r + 1;
        phi_r <= power_on_reset_in_n ? phi_r + 1 : 0;
        vsaw_r <= !local_pci_reset_out_n && (vsaw_r || !vme_sysreset_in_n);
    end
    ////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_apb_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("pready off its wait state");
    a_por_state: assert property ((!power_on_reset_in_n)[*8] |-> vme_sysreset_out &&
        !local_pci_reset_out_n && domain_reset.por && !vme_xcvr_out_enable)
        else $error("power-on reset state wrong");
    a_clk_only_por: assert property ($fell(domain_reset.clk_services_ok) |-> phi_r < 8)
        else $error("clock services cleared without power-on reset");
    a_req_vme: assert property ((!request_in_a_n)[*8] |-> vme_sysreset_out)
        else $error("reset request did not drive request_in_a out");
    a_vin_reset: assert property ((!vme_sysreset_in_n)[*8] |->
        !local_pci_reset_out_n && domain_reset.vme && options == '0)
        else $error("request_in_a input effects wrong");
    a_pin_reset: assert property ((!pci_reset_in_n && power_on_reset_in_n)[*8] |->
        domain_reset.general && !domain_reset.vme && options == '0)
        else $error("pci reset input effects wrong");
    a_vme_stretch: assert property ($fell(vme_sysreset_out) |-> vhi_r >= VME_STRETCH_CYC)
        else $error("request_in_a out too short");
    a_pci_stretch: assert property ($rose(local_pci_reset_out_n) |->
        vsaw_r || plo_r >= PCI_STRETCH_CYC)
        else $error("pci reset out too short");
    a_xcvr_late: assert property ($rose(vme_xcvr_out_enable) |-> phi_r >= 5)
        else $error("transceivers enabled before option capture");
    a_xcvr_soon: assert property ($rose(power_on_reset_in_n) ##1 power_on_reset_in_n[*8] |->
        ##[0:12] vme_xcvr_out_enable)
        else $error("transceivers not enabled after power-on");
endmodule : brol_top_props

bind brol_top brol_top_props #(.VME_STRETCH_CYC(VME_STRETCH_CYC),
    .PCI_STRETCH_CYC(PCI_STRETCH_CYC)) u_props (
    .mclk, .rst, .power_on_reset_in_n, .vme_sysreset_in_n, .pci_reset_in_n, .request_in_a_n,
    .psel, .penable, .pready, .vme_sysreset_out, .local_pci_reset_out_n, .vme_xcvr_out_enable,
    .domain_reset, .options);

/* File: sim/brol_top_test.sv */
// testbench: reset sequencing and power-up option latch
`timescale 1ns/10ps
module brol_top_test;
    import brol_pkg::*;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, vout, pout_n, sfail, xcvr, w64, err;
    logic [3:0] hold_n = 4'hA;
    logic [37:0] straps = '0;
    logic [5:0] ctl_n;
    logic [35:0] lines;
    brol_domain_type dom;
    brol_opt_type opts;
    int n_fail = 0, compares = 0, cyc = 0;

    always #4 mclk = ~mclk;
    brol_far_side far (.mclk, .hold_n, .straps, .xcvr_on(xcvr), .ctl_n, .lines);
    brol_top #(.VME_STRETCH_CYC(26'h32), .PCI_STRETCH_CYC(21'h14)) uut (
        .mclk, .rst, .power_on_reset_in_n(ctl_n[0]), .vme_sysreset_in_n(ctl_n[1]),
        .pci_reset_in_n(ctl_n[2]), .request_in_a_n(ctl_n[3]), .req64_n(ctl_n[4]),
        .bus_grant3_in_n(ctl_n[5]), .vme_addr_lines(lines[30:0]), .vme_data_lines(lines[35:31]),
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .vme_sysreset_out(vout), .local_pci_reset_out_n(pout_n), .sysfail_out(sfail),
        .vme_xcvr_out_enable(xcvr), .domain_reset(dom), .options(opts), .pci_width_status(w64));
    ////////////////////////////////////////////////////////////
    function automatic brol_opt_type exp_opt(input logic [35:0] s);
        return '{s[30], s[29:28], s[27:20], s[19], s[18:14], s[34], s[33], s[32], !s[31],
                 s[12], s[11], s[10:9], s[8:5], s[4:1], s[13], !s[0]};
    endfunction : exp_opt
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask : step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic vfall();
        for (int k = 0; k < 300 && vout !== 1'b0; k++) @(posedge mclk);
        chk("vme_out_end", vout, 1'b0);
    endtask : vfall
    task automatic conclude();
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        logic [37:0] s;
        brol_opt_type eo;
        void'($urandom(32'hB0E19036));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int it = 0; it < 2; it++) begin
            s = 38'({$urandom(), $urandom()});
            straps <= s;
            hold_n <= 4'hA;
            step(12);
            chk("por_out", {vout, pout_n, xcvr, dom}, 7'h4E);
            step(20);
            hold_n <= 4'hF;
            step(25);
            eo = exp_opt(s[35:0]);
            chk("opt_latch", opts, eo);
            chk("por_done", {xcvr, w64, sfail}, {1'b1, !s[36], eo.sysfail_assert});
            apb(1'b0, OFS_PCICFG, '0);
            chk("pcicfg", {err, rd[3:0]}, {1'b0, eo.pci_reg_base0_io, eo.bus_master_enable,
                eo.ti0_en & eo.ti0_io, eo.ti0_en & !eo.ti0_io});
            apb(1'b0, OFS_GENCTL, '0);
            chk("genctl", rd[4:0], {!s[37], eo.vme64_autoid_enable, eo.bus_isolation_mode, 2'h0});
            vfall();
            // fresh straps on the lines must not be taken up
            straps <= 38'({$urandom(), $urandom()});
            hold_n <= 4'hD;
            step(10);
            chk("vin", {pout_n, dom, opts}, {5'h07, 35'h0});
            hold_n <= 4'hF;
            step(25);
            apb(1'b0, OFS_GENCTL, '0);
            chk("vin_reload", {rd[4], w64, opts}, {!straps[37], !s[36], eo});
            straps <= 38'({$urandom(), $urandom()});
            hold_n <= 4'hB;
            step(10);
            chk("pin", {dom, opts}, {4'h3, 35'h0});
            hold_n <= 4'hF;
            step(25);
            chk("pin_reload", {w64, opts}, {!straps[36], eo});
        end
        apb(1'b1, OFS_GENCTL, 32'h1);
        step(2);
        chk("soft_pci", pout_n, 1'b0);
        step(30);
        apb(1'b1, OFS_GENCTL, 32'h0);
        step(3);
        chk("zero_write", {pout_n, vout}, 2'h2);
        apb(1'b1, OFS_GENCTL, 32'h2);
        step(2);
        chk("soft_vme", vout, 1'b1);
        vfall();
        hold_n <= 4'h7;
        step(10);
        chk("req_vme", vout, 1'b1);
        hold_n <= 4'hF;
        vfall();
        apb(1'b1, OFS_CSR_SET, 32'h3);
        step(40);
        apb(1'b0, OFS_CSR_SET, '0);
        chk("csr_set", {rd[1:0], pout_n, sfail}, 4'hD);
        apb(1'b1, OFS_CSR_CLR, 32'h1);
        step(3);
        chk("clr_reset", {pout_n, sfail}, 2'h3);
        apb(1'b1, OFS_CSR_CLR, 32'h2);
        step(3);
        chk("clr_fail", {pout_n, sfail}, 2'h2);
        apb(1'b0, 8'hF0, '0);
        chk("unmapped", {err, rd}, {1'b1, 32'h0});
        conclude();
    end
endmodule : brol_top_test
